/* File: hw/cpu_mode_ctrl.sv */
// Operating-mode controller: halt, sleep, io stop and system stop
`timescale 1ns/1ns
// Behaviour
// - Halt opcode enters halt, execution stops
// - Halt keeps clock, refresh, dma running; peripherals follow stop bit
// - Halt status output low throughout halt
// - Halt bus does repeated dummy opcode fetches
// - Six-clock low reset exits, restarts at zero
// - Enabled interrupt or nmi ends halt, responds
// - Masked interrupt leaves device halted
// - Two-byte sleep instruction enters sleep
// - Sleep stops cpu clock, refresh, dma only
// - Sleep still grants alternate master bus requests
// - Sleep parks address high, controls high while bus not granted, data released
// - External or internal interrupt ends sleep; nmi responds
// - Individually disabled interrupt ignored, sleep stays
// - Global enable set: exit sleep, respond
// - Global enable clear: exit sleep, resume next
// - Peripheral stop bit halts serial and timer units
// - Clearing stop bit restarts the peripherals
// - Stop bit plus sleep enters system stop
// - System stop exits like sleep, internal excluded
module cpu_mode_ctrl (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    resetPinN,             // Reset pin
  input  wire logic                    nmiPinN,               // Nmi pin
  input  wire logic                    extIrqZeroInN,         // Irq zero pin
  input  wire logic                    extIrqTwoInN,          // Irq two pin
  input  wire logic                    busRequestInN,         // Bus request pin
  input  wire logic                    opValid,               // Opcode byte executed
  input  wire logic [7:0]              opByte,                // That opcode byte
  input  wire logic                    machineCycleEnd,       // Bus may be released
  input  wire logic                    globalIrqEnableFlag,   // Global enable
  input  wire logic                    peripheralStopBit,     // Io stop control bit
  input  wire cpu_mode_pkg::irq_vec_t  irqEnable,             // Per-source enables
  input  wire logic                    serialIrq,             // Async serial irq
  input  wire logic                    csioIrq,               // Clocked serial irq
  input  wire logic                    timerIrq,              // Timer irq
  output logic                         haltN,                 // Halt status, low
  output logic                         fetchHold,             // Dummy fetch request
  output logic                         cpuReset,              // Cpu held in reset
  output logic                         busGrantOutN,          // Bus grant, low
  output cpu_mode_pkg::clk_gate_t      clkGate,               // Clock gates
  output cpu_mode_pkg::bus_park_t      busPark,               // Sleep bus parking
  output cpu_mode_pkg::wake_t          wakeOut                // Exit pulses
);

  // ==========================================================
  // Pin synchronisation and reset qualification
  logic [cpu_mode_pkg::PIN_COUNT-1:0] pinsSync;   // Filtered pin levels
  logic                               resetValid; // Reset held six clocks

  pin_sync u_pinSync (
    .mclk      (mclk),
    .rst       (rst),
    .pinsAsync ({busRequestInN, extIrqTwoInN, extIrqZeroInN, nmiPinN, resetPinN}),
    .pinsSync  (pinsSync)
  );

  reset_qualifier u_resetQual (
    .mclk       (mclk),
    .rst        (rst),
    .resetLow   (!pinsSync[cpu_mode_pkg::PIN_RESET]),
    .resetValid (resetValid)
  );

  // ==========================================================
  // Interrupt sources and opcode decode
  logic                   bus_request_in;      // Bus requested
  logic                   nmiLevel;    // Last nmi level seen
  logic                   nmiEdge;     // Nmi falling edge
  cpu_mode_pkg::irq_vec_t irqSrc;      // Pending maskable sources
  logic                   stopInternal; // Internal sources gated off
  logic                   wakeAny;     // Some enabled source active
  logic                   prefixSeen;  // Sleep prefix byte seen
  logic                   haltDec;     // Halt opcode executed
  logic                   sleepDec;    // Sleep instruction executed

  assign bus_request_in       = !pinsSync[cpu_mode_pkg::PIN_BUS_REQUEST];
  assign nmiEdge      = nmiLevel && !pinsSync[cpu_mode_pkg::PIN_NMI];
  assign irqSrc       = {!pinsSync[cpu_mode_pkg::PIN_IRQ_ZERO],
                         !pinsSync[cpu_mode_pkg::PIN_IRQ_TWO],
                         serialIrq, csioIrq, timerIrq};
  assign stopInternal = peripheralStopBit;
  assign wakeAny      = cpu_mode_pkg::anyWake(irqSrc, irqEnable, stopInternal);
  assign haltDec      = opValid && !prefixSeen
                        && (opByte == cpu_mode_pkg::HALT_OPCODE);
  assign sleepDec     = opValid && prefixSeen
                        && (opByte == cpu_mode_pkg::SLEEP_SECOND);

  // ==========================================================
  // Mode state and nmi latch
  cpu_mode_pkg::mode_t mode;          // Current operating mode
  cpu_mode_pkg::mode_t next_mode;
  logic                nmiPending;    // Latched nmi edge
  logic                next_nmiPending;
  logic                next_prefixSeen;
  logic                next_nmiLevel;
  cpu_mode_pkg::wake_t next_wakeOut;

  // Next mode, wake pulses and nmi latch
  always_comb begin
    next_mode       = mode;
    next_wakeOut    = cpu_mode_pkg::WAKE_NONE;
    next_nmiLevel   = pinsSync[cpu_mode_pkg::PIN_NMI];
    next_prefixSeen = prefixSeen;
    if (opValid) begin
      next_prefixSeen = (opByte == cpu_mode_pkg::SLEEP_PREFIX) && !prefixSeen;
    end
    unique case (mode)
      cpu_mode_pkg::ST_RUN: begin
        // Enter halt or sleep from executed instruction
        if (haltDec) begin
          next_mode = cpu_mode_pkg::ST_HALT;
        end else if (sleepDec && peripheralStopBit) begin
          next_mode = cpu_mode_pkg::ST_STOP;
        end else if (sleepDec) begin
          next_mode = cpu_mode_pkg::ST_SLEEP;
        end
      end
      cpu_mode_pkg::ST_HALT: begin
        // Nmi ignores global enable; masked sources keep halt
        if (nmiPending) begin
          next_wakeOut.nmi = 1'b1;
          next_mode        = cpu_mode_pkg::ST_RUN;
        end else if (wakeAny && globalIrqEnableFlag) begin
          next_wakeOut.maskable = 1'b1;
          next_mode             = cpu_mode_pkg::ST_RUN;
        end
      end
      cpu_mode_pkg::ST_SLEEP, cpu_mode_pkg::ST_STOP: begin
        // Sleep and system stop share the exit rules
        if (nmiPending) begin
          next_wakeOut.nmi = 1'b1;
          next_mode        = cpu_mode_pkg::ST_RUN;
        end else if (wakeAny && globalIrqEnableFlag) begin
          next_wakeOut.maskable = 1'b1;
          next_mode             = cpu_mode_pkg::ST_RUN;
        end else if (wakeAny) begin
          next_wakeOut.resumeNext = 1'b1;
          next_mode               = cpu_mode_pkg::ST_RUN;
        end
      end
      cpu_mode_pkg::ST_RESET: begin
        // Release restarts execution at address zero
        if (!resetValid) begin
          next_wakeOut.restart = 1'b1;
          next_mode            = cpu_mode_pkg::ST_RUN;
        end
      end
    endcase
    // Qualified reset wins over every mode
    if (resetValid) begin
      next_mode       = cpu_mode_pkg::ST_RESET;
      next_wakeOut    = cpu_mode_pkg::WAKE_NONE;
      next_prefixSeen = 1'b0;
    end
    // A new edge in the clearing cycle is kept
    if (next_wakeOut.nmi || mode == cpu_mode_pkg::ST_RUN || resetValid) begin
      next_nmiPending = nmiEdge;
    end else begin
      next_nmiPending = nmiPending || nmiEdge;
    end
  end

  // Mode registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode       <= cpu_mode_pkg::ST_RUN;
      nmiPending <= 1'b0;
      nmiLevel   <= 1'b1;
      prefixSeen <= 1'b0;
      wakeOut    <= cpu_mode_pkg::WAKE_NONE;
    end else begin
      mode       <= next_mode;
      nmiPending <= next_nmiPending;
      nmiLevel   <= next_nmiLevel;
      prefixSeen <= next_prefixSeen;
      wakeOut    <= next_wakeOut;
    end
  end

  // ==========================================================
  // Clock gates, bus grant, parking and status outputs
  logic                    stopped;         // Cpu stopped now
  logic                    nextStopped;     // Cpu stopped next
  logic                    next_haltN;
  logic                    next_fetchHold;
  logic                    next_cpuReset;
  logic                    next_busGrantOutN;
  cpu_mode_pkg::clk_gate_t next_clkGate;
  cpu_mode_pkg::bus_park_t next_busPark;

  assign stopped     = (mode == cpu_mode_pkg::ST_SLEEP) || (mode == cpu_mode_pkg::ST_STOP);
  assign nextStopped = (next_mode == cpu_mode_pkg::ST_SLEEP)
                       || (next_mode == cpu_mode_pkg::ST_STOP);

  // Status, cpu-side gate and park next values follow the next mode; grant and peripheral gate do not
  always_comb begin
    next_haltN    = (next_mode != cpu_mode_pkg::ST_HALT);
    next_fetchHold = (next_mode == cpu_mode_pkg::ST_HALT);
    next_cpuReset = (next_mode == cpu_mode_pkg::ST_RESET);
    // Grant at cycle end, or at once when the cpu is stopped
    next_busGrantOutN = !(bus_request_in && (!busGrantOutN || stopped || machineCycleEnd));
    // Halt keeps cpu clock, refresh, dma running; sleep stops cpu side; peripherals follow stop bit
    next_clkGate.cpuClock    = !nextStopped;
    next_clkGate.refresh     = !nextStopped;
    next_clkGate.dma         = !nextStopped;
    next_clkGate.peripherals = !peripheralStopBit;
    // Address and controls parked only while the cpu owns the bus; data released whenever stopped
    next_busPark.addrHigh     = nextStopped && next_busGrantOutN;
    next_busPark.ctrlInactive = nextStopped && next_busGrantOutN;
    next_busPark.dataRelease  = nextStopped;
  end

  // Output registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      haltN        <= 1'b1;
      fetchHold    <= 1'b0;
      cpuReset     <= 1'b0;
      busGrantOutN <= 1'b1;
      clkGate      <= cpu_mode_pkg::GATE_RESET;
      busPark      <= cpu_mode_pkg::PARK_RESET;
    end else begin
      haltN        <= next_haltN;
      fetchHold    <= next_fetchHold;
      cpuReset     <= next_cpuReset;
      busGrantOutN <= next_busGrantOutN;
      clkGate      <= next_clkGate;
      busPark      <= next_busPark;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_haltEntry;
    mode == cpu_mode_pkg::ST_RUN && haltDec && !resetValid
      |=> mode == cpu_mode_pkg::ST_HALT && !haltN && fetchHold;
  endproperty
  a_haltEntry: assert property (p_haltEntry) else $error("halt not entered");
  property p_haltStatus;
    mode == cpu_mode_pkg::ST_HALT |-> !haltN && fetchHold && clkGate.cpuClock && clkGate.dma;
  endproperty
  a_haltStatus: assert property (p_haltStatus) else $error("halt outputs wrong");
  property p_haltNmi;
    mode == cpu_mode_pkg::ST_HALT && nmiPending && !resetValid
      |=> wakeOut.nmi && mode == cpu_mode_pkg::ST_RUN ##1 !wakeOut.nmi;
  endproperty
  a_haltNmi: assert property (p_haltNmi) else $error("nmi did not end halt");
  property p_haltMasked;
    mode == cpu_mode_pkg::ST_HALT && !nmiPending && !(wakeAny && globalIrqEnableFlag)
      && !resetValid |=> mode == cpu_mode_pkg::ST_HALT && wakeOut == cpu_mode_pkg::WAKE_NONE;
  endproperty
  a_haltMasked: assert property (p_haltMasked) else $error("masked irq left halt");
  property p_stopEntry;
    mode == cpu_mode_pkg::ST_RUN && sleepDec && peripheralStopBit && !resetValid
      |=> mode == cpu_mode_pkg::ST_STOP && !clkGate.cpuClock && !clkGate.peripherals;
  endproperty
  a_stopEntry: assert property (p_stopEntry) else $error("system stop not entered");
  property p_sleepGates;
    stopped |-> !clkGate.cpuClock && !clkGate.refresh && !clkGate.dma && busPark.dataRelease;
  endproperty
  a_sleepGates: assert property (p_sleepGates) else $error("sleep gates wrong");
  property p_periphGate;
    ##1 clkGate.peripherals == !$past(peripheralStopBit);
  endproperty
  a_periphGate: assert property (p_periphGate) else $error("peripheral gate wrong");
  property p_sleepGrant;
    stopped && bus_request_in |=> !busGrantOutN && !busPark.addrHigh;
  endproperty
  a_sleepGrant: assert property (p_sleepGrant) else $error("no grant in sleep");
  property p_sleepResume;
    stopped && !nmiPending && wakeAny && !globalIrqEnableFlag && !resetValid
      |=> wakeOut.resumeNext && !wakeOut.maskable && mode == cpu_mode_pkg::ST_RUN;
  endproperty
  a_sleepResume: assert property (p_sleepResume) else $error("sleep resume wrong");
  property p_sleepIgnore;
    stopped && !nmiPending && !wakeAny && !resetValid |=> $stable(mode);
  endproperty
  a_sleepIgnore: assert property (p_sleepIgnore) else $error("disabled irq woke");
  property p_restart;
    mode == cpu_mode_pkg::ST_RESET && !resetValid |=> wakeOut.restart && !cpuReset;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after reset");
  // Parked bus whenever stopped and the bus is still ours
  property p_sleepPark;
    stopped && busGrantOutN
      |-> busPark.addrHigh && busPark.ctrlInactive && busPark.dataRelease;
  endproperty
  a_sleepPark: assert property (p_sleepPark) else $error("sleep bus not parked");
  // Nmi always ends sleep and system stop
  property p_sleepNmi;
    stopped && nmiPending && !resetValid |=> wakeOut.nmi && mode == cpu_mode_pkg::ST_RUN;
  endproperty
  a_sleepNmi: assert property (p_sleepNmi) else $error("nmi did not end sleep");
  // Globally enabled source leaves sleep with a response
  property p_sleepRespond;
    stopped && !nmiPending && wakeAny && globalIrqEnableFlag && !resetValid
      |=> wakeOut.maskable && mode == cpu_mode_pkg::ST_RUN;
  endproperty
  a_sleepRespond: assert property (p_sleepRespond) else $error("sleep response wrong");

  c_haltWake: cover property (mode == cpu_mode_pkg::ST_HALT ##1 wakeOut.maskable);
  c_sleepResume: cover property (mode == cpu_mode_pkg::ST_SLEEP ##1 wakeOut.resumeNext);
  c_stopNmi: cover property (mode == cpu_mode_pkg::ST_STOP ##1 wakeOut.nmi);
  c_reset: cover property (mode == cpu_mode_pkg::ST_HALT ##1 mode == cpu_mode_pkg::ST_RESET);
endmodule : cpu_mode_ctrl

/* File: hw/cpu_mode_pkg.sv */
// Shared constants and types for the CPU operating-mode controller
package cpu_mode_pkg;

  // ==========================================================
  // Instruction codes seen by the mode decoder
  localparam logic [7:0] HALT_OPCODE   = 8'h76; // Single-byte halt
  localparam logic [7:0] SLEEP_PREFIX  = 8'hed; // First byte of sleep
  localparam logic [7:0] SLEEP_SECOND  = 8'h76; // Second byte of sleep

  // ==========================================================
  // Reset pin qualification
  localparam int         RESET_MIN_CYCLES = 6;    // Least low time in clocks
  localparam logic [2:0] RESET_CNT_MAX    = 3'(RESET_MIN_CYCLES);

  // ==========================================================
  // Pin vector layout and idle level
  localparam int         PIN_COUNT       = 5;
  localparam int         PIN_RESET       = 0;     // Reset pin, low active
  localparam int         PIN_NMI         = 1;     // Non-maskable, falling edge
  localparam int         PIN_IRQ_ZERO    = 2;     // Ext irq zero, low level
  localparam int         PIN_IRQ_TWO     = 3;     // Ext irq two, low level
  localparam int         PIN_BUS_REQUEST = 4;     // Bus request, low active
  localparam logic [4:0] PIN_IDLE        = 5'h1f; // All pins idle high

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_RUN   = 5'h01, // Normal execution, also io stop
    ST_HALT  = 5'h02, // Halt, clocks running
    ST_SLEEP = 5'h04, // Sleep, cpu clock stopped
    ST_STOP  = 5'h08, // System stop, cpu and peripherals stopped
    ST_RESET = 5'h10  // Qualified reset held
  } mode_t;

  typedef struct packed {
    logic irqZero; // External irq zero
    logic irqTwo;  // External irq two
    logic serial; // Async serial unit
    logic csio;   // Clocked serial unit
    logic timer;  // Programmable reload timer
  } irq_vec_t;

  typedef struct packed {
    logic cpuClock;    // Internal cpu clock enable
    logic refresh;     // Refresh cycle insertion enable
    logic dma;         // Dma controller enable
    logic peripherals; // Serial and timer units enable
  } clk_gate_t;

  typedef struct packed {
    logic addrHigh;     // Force address outputs high
    logic ctrlInactive; // Force control outputs inactive high
    logic dataRelease;  // Data bus released
  } bus_park_t;

  typedef struct packed {
    logic nmi;        // Start non-maskable response
    logic maskable;   // Start maskable response
    logic resumeNext; // Resume after sleep, no response
    logic restart;    // Restart at address zero
  } wake_t;

  localparam clk_gate_t GATE_RESET = 4'hf; // All running after reset
  localparam bus_park_t PARK_RESET = 3'h0; // Bus not parked after reset
  localparam wake_t     WAKE_NONE  = 4'h0; // No wake pulse

  // Any enabled maskable source; internal ones dropped when stopped
  function automatic logic anyWake(irq_vec_t src, irq_vec_t en,
                                   logic internalStopped);
    irq_vec_t live;
    live = src & en;
    if (internalStopped) begin
      live.serial = 1'b0;
      live.csio   = 1'b0;
      live.timer  = 1'b0;
    end
    return |live;
  endfunction : anyWake

endpackage : cpu_mode_pkg

/* File: hw/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
  input  wire logic                               mclk,
  input  wire logic                               rst,
  input  wire logic [cpu_mode_pkg::PIN_COUNT-1:0] pinsAsync,
  output logic      [cpu_mode_pkg::PIN_COUNT-1:0] pinsSync
);
  logic [cpu_mode_pkg::PIN_COUNT-1:0] stage1;      // Read only by stage2
  logic [cpu_mode_pkg::PIN_COUNT-1:0] stage2;      // Second stage
  logic [cpu_mode_pkg::PIN_COUNT-1:0] stage3;      // Third stage
  logic [cpu_mode_pkg::PIN_COUNT-1:0] next_pinsSync;

  // ==========================================================
  // Accept a change only when stages two and three agree
  always_comb begin
    for (int i = 0; i < cpu_mode_pkg::PIN_COUNT; i++) begin
      next_pinsSync[i] = (stage2[i] == stage3[i]) ? stage3[i] : pinsSync[i];
    end
  end

  // Stage registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1   <= cpu_mode_pkg::PIN_IDLE;
      stage2   <= cpu_mode_pkg::PIN_IDLE;
      stage3   <= cpu_mode_pkg::PIN_IDLE;
      pinsSync <= cpu_mode_pkg::PIN_IDLE;
    end else begin
      stage1   <= pinsAsync;
      stage2   <= stage1;
      stage3   <= stage2;
      pinsSync <= next_pinsSync;
    end
  end
endmodule : pin_sync

/* File: hw/reset_qualifier.sv */
// Reset pin qualifier: accepts only a low of six or more clocks
`timescale 1ns/1ns
module reset_qualifier (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic resetLow,   // Synchronised pin level, high while low
  output logic      resetValid  // Qualified reset level
);
  logic [2:0] lowCount;       // Consecutive low clocks, saturating
  logic [2:0] next_lowCount;
  logic       next_resetValid;

  // ==========================================================
  // Count consecutive lows; a short pulse restarts the count
  always_comb begin
    if (!resetLow) begin
      next_lowCount = 3'h0;
    end else if (lowCount == cpu_mode_pkg::RESET_CNT_MAX) begin
      next_lowCount = lowCount;
    end else begin
      next_lowCount = lowCount + 3'h1;
    end
    next_resetValid = resetLow && (next_lowCount == cpu_mode_pkg::RESET_CNT_MAX);
  end

  // Counter registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lowCount   <= 3'h0;
      resetValid <= 1'b0;
    end else begin
      lowCount   <= next_lowCount;
      resetValid <= next_resetValid;
    end
  end

  // ==========================================================
  // Checks
  property p_longLow;
    @(posedge mclk) disable iff (rst) resetLow [*6] |=> resetValid;
  endproperty
  a_longLow: assert property (p_longLow) else $error("six low clocks not taken");
  property p_shortLow;
    @(posedge mclk) disable iff (rst) !resetLow ##1 resetLow [*5] |=> !resetValid;
  endproperty
  a_shortLow: assert property (p_shortLow) else $error("short reset accepted");
endmodule : reset_qualifier

/* File: test/bus_master_model.sv */
// Alternate bus master that asks for the bus and waits for the grant
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic want,          // Bench wants the bus
  input  wire logic busGrantOutN,  // Grant from the device, low
  output logic      busRequestInN, // Request to the device, low
  output logic      owned          // Bus currently granted to us
);
  // ==========================================================
  // Request stands until the bench drops it after the grant
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busRequestInN <= 1'b1;
      owned         <= 1'b0;
    end else begin
      busRequestInN <= !want;
      owned         <= !busGrantOutN;
    end
  end
endmodule : bus_master_model

/* File: test/tb.sv */
// Self-checking testbench for the operating-mode controller
`timescale 1ns/1ns
module tb;
  logic mclk = 1'b0, rst = 1'b1, want = 1'b0, owned;
  logic resetPinN = 1'b1, nmiPinN = 1'b1, extIrqZeroInN = 1'b1, extIrqTwoInN = 1'b1;
  logic busRequestInN, opValid = 1'b0, machineCycleEnd = 1'b1;
  logic [7:0] opByte = 8'h00;
  logic globalIrqEnableFlag = 1'b0, peripheralStopBit = 1'b0;
  logic serialIrq = 1'b0, csioIrq = 1'b0, timerIrq = 1'b0;
  cpu_mode_pkg::irq_vec_t  irqEnable = 5'h00; // {irqZero,irqTwo,serial,csio,timer}
  logic haltN, fetchHold, cpuReset, busGrantOutN;
  cpu_mode_pkg::clk_gate_t clkGate;
  cpu_mode_pkg::bus_park_t busPark;
  cpu_mode_pkg::wake_t     wakeOut;  // {nmi,maskable,resumeNext,restart}
  int mismatches = 0, total_checks = 0;
  always #25 mclk = ~mclk; // 20 MHz
  cpu_mode_ctrl cpu_mode_ctrl_i (.mclk(mclk), .rst(rst), .resetPinN(resetPinN),
    .nmiPinN(nmiPinN), .extIrqZeroInN(extIrqZeroInN), .extIrqTwoInN(extIrqTwoInN),
    .busRequestInN(busRequestInN), .opValid(opValid), .opByte(opByte),
    .machineCycleEnd(machineCycleEnd), .globalIrqEnableFlag(globalIrqEnableFlag),
    .peripheralStopBit(peripheralStopBit), .irqEnable(irqEnable), .serialIrq(serialIrq),
    .csioIrq(csioIrq), .timerIrq(timerIrq), .haltN(haltN), .fetchHold(fetchHold),
    .cpuReset(cpuReset), .busGrantOutN(busGrantOutN), .clkGate(clkGate),
    .busPark(busPark), .wakeOut(wakeOut));
  bus_master_model bus_master_model_i (.mclk(mclk), .rst(rst), .want(want),
    .busGrantOutN(busGrantOutN), .busRequestInN(busRequestInN), .owned(owned));
  // ==========================================================
  // Shared helpers
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic op(input logic [7:0] b); // One executed opcode byte
    @(posedge mclk);
    opValid <= 1'b1;
    opByte  <= b;
    @(posedge mclk);
    opValid <= 1'b0;
    @(negedge mclk);
  endtask : op
  task automatic waitWake(input logic [3:0] mask); // Bounded wait for a wake pulse
    int i;
    for (i = 0; i < 24 && (wakeOut & mask) == 4'h0; i++) @(negedge mclk);
    if (i == 24) begin
      mismatches++;
      final_report();
    end
  endtask : waitWake
  // ==========================================================
  // Scenarios
  task automatic t_halt();
    op(8'h76);
    chk(8'(haltN), 8'h00);
    chk(8'(fetchHold), 8'h01);
    chk(8'(clkGate), 8'h0f);
    @(posedge mclk);
    irqEnable <= 5'h10;
    extIrqZeroInN <= 1'b0;
    tick(12);
    chk(8'(haltN), 8'h00);
    @(posedge mclk);
    extIrqZeroInN <= 1'b1;
    nmiPinN <= 1'b0;
    waitWake(4'h8);
    chk(8'(wakeOut), 8'h08);
    @(posedge mclk);
    nmiPinN <= 1'b1;
    tick(1);
    chk(8'(haltN), 8'h01);
    op(8'h76);
    @(posedge mclk);
    globalIrqEnableFlag <= 1'b1;
    irqEnable <= 5'h08;
    extIrqTwoInN <= 1'b0;
    waitWake(4'h4);
    chk(8'({wakeOut, haltN}), 8'h09);
    @(posedge mclk);
    extIrqTwoInN <= 1'b1;
    globalIrqEnableFlag <= 1'b0;
    irqEnable <= 5'h00;
  endtask : t_halt
  task automatic t_sleep();
    int i;
    op(8'hed);
    op(8'h76);
    chk(8'(clkGate), 8'h01);
    chk(8'(busPark), 8'h07);
    @(posedge mclk);
    irqEnable <= 5'h00;
    serialIrq <= 1'b1;
    tick(12);
    chk(8'(clkGate), 8'h01);
    @(posedge mclk);
    irqEnable <= 5'h04;
    waitWake(4'h2);
    chk(8'(wakeOut), 8'h02);
    @(posedge mclk);
    serialIrq <= 1'b0;
    op(8'hed);
    op(8'h76);
    @(posedge mclk);
    want <= 1'b1;
    for (i = 0; i < 20 && busGrantOutN !== 1'b0; i++) @(negedge mclk);
    if (i == 20) begin
      mismatches++;
      final_report();
    end
    tick(1);
    chk(8'({owned, busGrantOutN, busPark}), 8'h11);
    @(posedge mclk);
    want <= 1'b0;
    tick(8);
    chk(8'(busPark), 8'h07);
    @(posedge mclk);
    globalIrqEnableFlag <= 1'b1;
    irqEnable <= 5'h08;
    extIrqTwoInN <= 1'b0;
    waitWake(4'h4);
    chk(8'(wakeOut), 8'h04);
    @(posedge mclk);
    extIrqTwoInN <= 1'b1;
  endtask : t_sleep
  task automatic t_stop();
    @(posedge mclk);
    peripheralStopBit <= 1'b1;
    tick(3);
    chk(8'(clkGate), 8'h0e);
    op(8'hed);
    op(8'h76);
    chk(8'(clkGate), 8'h00);
    @(posedge mclk);
    irqEnable <= 5'h11;
    timerIrq <= 1'b1;
    tick(12);
    chk(8'(clkGate), 8'h00);
    @(posedge mclk);
    nmiPinN <= 1'b0;
    waitWake(4'h8);
    chk(8'(wakeOut), 8'h08);
    @(posedge mclk);
    nmiPinN <= 1'b1;
    op(8'hed);
    op(8'h76);
    chk(8'(clkGate), 8'h00);
    @(posedge mclk);
    extIrqZeroInN <= 1'b0;
    waitWake(4'h4);
    chk(8'(wakeOut), 8'h04);
    @(posedge mclk);
    extIrqZeroInN <= 1'b1;
    timerIrq <= 1'b0;
    peripheralStopBit <= 1'b0;
    tick(3);
    chk(8'(clkGate), 8'h0f);
    @(posedge mclk);
    machineCycleEnd <= 1'b0;
    want <= 1'b1;
    tick(8);
    chk(8'(busGrantOutN), 8'h01);
    @(posedge mclk);
    machineCycleEnd <= 1'b1;
    tick(2);
    chk(8'(busGrantOutN), 8'h00);
    @(posedge mclk);
    want <= 1'b0;
    tick(8);
  endtask : t_stop
  task automatic t_reset();
    op(8'h76);
    @(posedge mclk);
    resetPinN <= 1'b0;
    tick(4);
    @(posedge mclk);
    resetPinN <= 1'b1;
    tick(12);
    chk(8'({haltN, cpuReset}), 8'h00);
    @(posedge mclk);
    resetPinN <= 1'b0;
    tick(14);
    chk(8'(cpuReset), 8'h01);
    @(posedge mclk);
    resetPinN <= 1'b1;
    waitWake(4'h1);
    chk(8'(wakeOut), 8'h01);
    chk(8'(haltN), 8'h01);
  endtask : t_reset
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    tick(2);
    t_halt();
    t_sleep();
    t_stop();
    t_reset();
    final_report();
  end
endmodule : tb
